// ---- logic/adc_regs_map.svh ----
// Register map constants of the converter configuration and status bank
`ifndef ADC_REGS_MAP_SVH
`define ADC_REGS_MAP_SVH

// ----------------------------------------------------------------
// Opcodes
// ----------------------------------------------------------------
`define OP_NOP        8'h00
`define OP_READ       8'h10
`define OP_WRITE      8'h08
`define OP_SET_BITS   8'h18
`define OP_CLEAR_BITS 8'h20

// ----------------------------------------------------------------
// Register addresses
// ----------------------------------------------------------------
`define A_DEVICE_STATE_FLAGS    8'h00
`define A_GLOBAL_CONTROL        8'h01
`define A_OUTPUT_FORMAT_CTRL    8'h02
`define A_AVERAGING_RATIO       8'h03
`define A_CONVERSION_CLOCK_CTRL 8'h04
`define A_CHANNEL_KIND_SELECT   8'h05
`define A_DIGITAL_DIRECTION     8'h07
`define A_OUTPUT_DRIVE_TYPE     8'h09
`define A_DIGITAL_OUT_LEVELS    8'h0B
`define A_DIGITAL_IN_LEVELS     8'h0D
`define A_SEQUENCER_CTRL        8'h10
`define A_MANUAL_CHANNEL_PICK   8'h11
`define A_SCAN_CHANNEL_MASK     8'h12
`define A_TEST_UNLOCK_KEY       8'hBF
`define A_TEST_ENABLE           8'hC0
`define A_BIT_CAPTURE_LOW       8'hC1
`define A_BIT_CAPTURE_HIGH      8'hC2

// ----------------------------------------------------------------
// Field positions and reset values
// ----------------------------------------------------------------
`define B_FIXED_ONE      7
`define B_SCAN_RUNNING   6
`define B_POWERUP_FAIL   2
`define B_INBOUND_FAIL   1
`define B_SUPPLY_DROP    0
`define B_SOFT_RESET     0
`define R_STATUS_FLAGS   8'h81
`define R_CLOCK_CTRL     8'h01
`define R_ZERO           8'h00
`define FRAME_BITS       24

`endif

// ---- logic/adc_regs_pkg.sv ----
// Types shared by the register bank
`default_nettype none
package adc_regs_pkg;
    // Decoded command of a finished frame
    typedef enum logic [4:0] {
        CMD_NONE  = 5'b00001,
        CMD_READ  = 5'b00010,
        CMD_WRITE = 5'b00100,
        CMD_SET   = 5'b01000,
        CMD_CLEAR = 5'b10000
    } cmd_t;
endpackage
`default_nettype wire

// ---- logic/adc_reg_store.sv ----
// Byte-wide storage of the plain read/write registers
`timescale 1ns/1ps
`default_nettype none
`include "adc_regs_map.svh"
module adc_reg_store #(
    parameter int DEPTH = 16
) (
    input wire logic i_clk,
    input wire logic i_reset_n,
    input wire logic i_clear,
    input wire logic i_we,
    input wire logic [3:0] i_waddr,
    input wire logic [7:0] i_wdata,
    input wire logic [3:0] i_raddr,
    output logic [7:0] o_rdata
);
    logic [7:0] mem_reg [DEPTH];
    logic [7:0] mem_next [DEPTH];
    logic [7:0] rdata_reg;
    logic [7:0] rdata_next;

    // Slot 3 holds the clock control; it alone resets to one
    always_comb begin
        for (int i = 0; i < DEPTH; i++) begin
            mem_next[i] = mem_reg[i];
            if (i_clear) begin
                mem_next[i] = (i == 3) ? `R_CLOCK_CTRL : `R_ZERO;
            end else if (i_we && i_waddr == 4'(i)) begin
                mem_next[i] = i_wdata;
            end
        end
        rdata_next = mem_reg[i_raddr];
    end

    // Registered read port
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            for (int i = 0; i < DEPTH; i++) begin
                mem_reg[i] <= (i == 3) ? `R_CLOCK_CTRL : `R_ZERO;
            end
            rdata_reg <= `R_ZERO;
        end else begin
            mem_reg <= mem_next;
            rdata_reg <= rdata_next;
        end
    end

    assign o_rdata = rdata_reg;
endmodule // adc_reg_store
`default_nettype wire

// ---- logic/adc_config_status_regs.sv ----
// Serial-framed configuration and status register bank
`timescale 1ns/1ps
`default_nettype none
`include "adc_regs_map.svh"
module adc_config_status_regs (
    input wire logic i_clk,
    input wire logic i_reset_n,
    input wire logic i_cs_n,
    input wire logic i_sclk,
    input wire logic i_sdi,
    input wire logic i_scan_running,
    input wire logic i_powerup_check_fail,
    input wire logic i_inbound_check_fail,
    input wire logic i_supply_drop,
    input wire logic [7:0] i_digital_in_levels,
    output logic o_sdo,
    output logic o_soft_reset_pulse
);
    // ----------------------------------------------------------------
    // Pin synchronisers
    // ----------------------------------------------------------------
    logic [1:0] cs_sync_reg, sclk_sync_reg, sdi_sync_reg;
    logic [1:0] run_sync_reg, pf_sync_reg, inf_sync_reg, drop_sync_reg;
    logic cs_prev_reg, sclk_prev_reg, inf_prev_reg;
    // Pin-fed byte is a level only; a byte caught mid-change may mix
    // old and new bits, which a host polling it can live with
    logic [7:0] din_meta_reg, din_sync_reg;

    // First stage feeds only the second stage
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            cs_sync_reg <= 2'h3;
            sclk_sync_reg <= 2'h0;
            sdi_sync_reg <= 2'h0;
            run_sync_reg <= 2'h0;
            pf_sync_reg <= 2'h0;
            inf_sync_reg <= 2'h0;
            drop_sync_reg <= 2'h0;
            cs_prev_reg <= 1'b1;
            sclk_prev_reg <= 1'b0;
            inf_prev_reg <= 1'b0;
            din_meta_reg <= 8'h00;
            din_sync_reg <= 8'h00;
        end else begin
            cs_sync_reg <= {cs_sync_reg[0], i_cs_n};
            sclk_sync_reg <= {sclk_sync_reg[0], i_sclk};
            sdi_sync_reg <= {sdi_sync_reg[0], i_sdi};
            run_sync_reg <= {run_sync_reg[0], i_scan_running};
            pf_sync_reg <= {pf_sync_reg[0], i_powerup_check_fail};
            inf_sync_reg <= {inf_sync_reg[0], i_inbound_check_fail};
            drop_sync_reg <= {drop_sync_reg[0], i_supply_drop};
            cs_prev_reg <= cs_sync_reg[1];
            sclk_prev_reg <= sclk_sync_reg[1];
            inf_prev_reg <= inf_sync_reg[1];
            din_meta_reg <= i_digital_in_levels;
            din_sync_reg <= din_meta_reg;
        end
    end

    logic cs_low, cs_rise, cs_fall, sclk_rise, sclk_fall, inf_event;
    assign cs_low = !cs_sync_reg[1];
    assign cs_rise = cs_sync_reg[1] && !cs_prev_reg;
    assign cs_fall = !cs_sync_reg[1] && cs_prev_reg;
    assign sclk_rise = sclk_sync_reg[1] && !sclk_prev_reg;
    assign sclk_fall = !sclk_sync_reg[1] && sclk_prev_reg;
    assign inf_event = inf_sync_reg[1] && !inf_prev_reg;

    // ----------------------------------------------------------------
    // Helper functions
    // ----------------------------------------------------------------
    // Map a byte address onto a storage slot; bit 4 means unmapped
    function automatic logic [4:0] slot_of(input logic [7:0] a);
        case (a)
            `A_GLOBAL_CONTROL:        slot_of = 5'h00;
            `A_OUTPUT_FORMAT_CTRL:    slot_of = 5'h01;
            `A_AVERAGING_RATIO:       slot_of = 5'h02;
            `A_CONVERSION_CLOCK_CTRL: slot_of = 5'h03;
            `A_CHANNEL_KIND_SELECT:   slot_of = 5'h04;
            `A_DIGITAL_DIRECTION:     slot_of = 5'h05;
            `A_OUTPUT_DRIVE_TYPE:     slot_of = 5'h06;
            `A_DIGITAL_OUT_LEVELS:    slot_of = 5'h07;
            `A_SEQUENCER_CTRL:        slot_of = 5'h08;
            `A_MANUAL_CHANNEL_PICK:   slot_of = 5'h09;
            `A_SCAN_CHANNEL_MASK:     slot_of = 5'h0A;
            `A_TEST_UNLOCK_KEY:       slot_of = 5'h0B;
            `A_TEST_ENABLE:           slot_of = 5'h0C;
            `A_BIT_CAPTURE_LOW:       slot_of = 5'h0D;
            `A_BIT_CAPTURE_HIGH:      slot_of = 5'h0E;
            default:                  slot_of = 5'h10;
        endcase
    endfunction

    // Apply write, set or clear to an old byte
    function automatic logic [7:0] modify(input adc_regs_pkg::cmd_t c,
            input logic [7:0] old, input logic [7:0] d);
        case (c)
            adc_regs_pkg::CMD_WRITE: modify = d;
            adc_regs_pkg::CMD_SET:   modify = old | d;
            adc_regs_pkg::CMD_CLEAR: modify = old & ~d;
            default:                 modify = old;
        endcase
    endfunction

    // ----------------------------------------------------------------
    // Frame shifter
    // ----------------------------------------------------------------
    logic [23:0] shift_reg, shift_next;
    logic [4:0] count_reg, count_next;
    logic [7:0] out_reg, out_next;
    logic sdo_reg, sdo_next;
    logic [7:0] read_byte_reg, read_byte_next;

    // Capture SDI on rising SCLK, shift the read byte out on falling SCLK
    always_comb begin
        shift_next = shift_reg;
        count_next = count_reg;
        out_next = out_reg;
        sdo_next = sdo_reg;
        if (cs_fall) begin
            count_next = 5'h00;
            out_next = {read_byte_reg[6:0], 1'b0};
            sdo_next = read_byte_reg[7];
        end else if (cs_low) begin
            if (sclk_rise && count_reg != 5'(`FRAME_BITS)) begin
                shift_next = {shift_reg[22:0], sdi_sync_reg[1]};
                count_next = count_reg + 5'h01;
            end
            if (sclk_fall) begin
                sdo_next = out_reg[7];
                out_next = {out_reg[6:0], 1'b0};
            end
        end else begin
            sdo_next = 1'b0;
        end
    end

    // ----------------------------------------------------------------
    // Command decode on chip-select release
    // ----------------------------------------------------------------
    adc_regs_pkg::cmd_t cmd;
    logic [7:0] f_addr, f_data;
    logic [4:0] f_slot;
    logic frame_done;
    assign f_addr = shift_reg[15:8];
    assign f_data = shift_reg[7:0];
    assign f_slot = slot_of(f_addr);
    // Only a full 24-bit frame is acted upon
    assign frame_done = cs_rise && count_reg == 5'(`FRAME_BITS);

    always_comb begin
        case (shift_reg[23:16])
            `OP_READ:       cmd = adc_regs_pkg::CMD_READ;
            `OP_WRITE:      cmd = adc_regs_pkg::CMD_WRITE;
            `OP_SET_BITS:   cmd = adc_regs_pkg::CMD_SET;
            `OP_CLEAR_BITS: cmd = adc_regs_pkg::CMD_CLEAR;
            default:        cmd = adc_regs_pkg::CMD_NONE;
        endcase
    end

    // ----------------------------------------------------------------
    // Status flags and store control
    // ----------------------------------------------------------------
    logic inbound_fail_reg, inbound_fail_next;
    logic supply_drop_reg, supply_drop_next;
    logic powerup_fail_reg, powerup_fail_next;
    logic soft_rst_reg, soft_rst_next;
    logic [7:0] store_rdata, status_byte, gc_new;
    logic modifying, allowed, store_we;
    logic [7:0] store_wdata;

    assign modifying = frame_done && (cmd == adc_regs_pkg::CMD_WRITE ||
        cmd == adc_regs_pkg::CMD_SET || cmd == adc_regs_pkg::CMD_CLEAR);
    // Error flag fences writes, sets and clears past the first two addresses; reads still pass
    assign allowed = !inbound_fail_reg || f_addr == `A_DEVICE_STATE_FLAGS ||
        f_addr == `A_GLOBAL_CONTROL;
    assign status_byte = {1'b1, run_sync_reg[1], 3'h0, powerup_fail_reg,
        inbound_fail_reg, supply_drop_reg};
    logic [7:0] gc_reg, gc_next;

    // Global control lives outside the store, so its set and clear
    // commands must start from its own register
    assign gc_new = modify(cmd, gc_reg, f_data);
    // Store read port is pointed at the frame address ahead of time, so
    // its registered data is valid by the chip-select rising edge
    assign store_we = modifying && allowed && !f_slot[4] &&
        f_addr != `A_GLOBAL_CONTROL;
    assign store_wdata = modify(cmd, store_rdata, f_data);

    // ----------------------------------------------------------------
    // Power-up check capture
    // ----------------------------------------------------------------
    // The check pin is read once its synchroniser has filled after a
    // power reset, so the first edges after release cannot latch the
    // synchroniser's reset value; a soft reset reads it again below
    logic [2:0] pf_armed_reg, pf_armed_next;
    logic pf_load;
    assign pf_armed_next = {pf_armed_reg[1:0], 1'b1};
    assign pf_load = pf_armed_reg[1] && !pf_armed_reg[2];

    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            pf_armed_reg <= 3'h0;
        end else begin
            pf_armed_reg <= pf_armed_next;
        end
    end

    always_comb begin
        inbound_fail_next = inbound_fail_reg;
        supply_drop_next = supply_drop_reg;
        powerup_fail_next = powerup_fail_reg;
        gc_next = gc_reg;
        soft_rst_next = 1'b0;
        read_byte_next = read_byte_reg;
        if (modifying && allowed && f_addr == `A_DEVICE_STATE_FLAGS) begin
            // Only write-one-to-clear bits respond; set-bit does nothing
            if (cmd != adc_regs_pkg::CMD_SET && f_data[`B_INBOUND_FAIL])
                inbound_fail_next = 1'b0;
            if (cmd != adc_regs_pkg::CMD_SET && f_data[`B_SUPPLY_DROP])
                supply_drop_next = 1'b0;
        end
        if (modifying && allowed && f_addr == `A_GLOBAL_CONTROL) begin
            // Reset bit is write-only and self clearing
            gc_next = {gc_new[7:6], 2'h0, gc_new[3:1], 1'b0};
            soft_rst_next = gc_new[`B_SOFT_RESET];
        end
        // Read byte is latched at select release and shifted out next frame
        if (frame_done && cmd == adc_regs_pkg::CMD_READ) begin
            if (f_addr == `A_DEVICE_STATE_FLAGS)
                read_byte_next = status_byte;
            else if (f_addr == `A_GLOBAL_CONTROL)
                read_byte_next = gc_reg;
            else if (f_addr == `A_DIGITAL_IN_LEVELS)
                read_byte_next = din_sync_reg;
            else if (f_slot[4])
                read_byte_next = `R_ZERO;
            else
                read_byte_next = store_rdata;
        end
        if (soft_rst_reg) begin
            gc_next = `R_ZERO;
            inbound_fail_next = 1'b0;
            supply_drop_next = 1'b1;
            powerup_fail_next = pf_sync_reg[1];
        end
        // After a power reset the check pin is read once, when its
        // synchroniser holds the settled level
        if (pf_load)
            powerup_fail_next = pf_sync_reg[1];
        // Set wins over any clear in the same cycle
        if (inf_event)
            inbound_fail_next = 1'b1;
        if (drop_sync_reg[1])
            supply_drop_next = 1'b1;
    end

    // ----------------------------------------------------------------
    // Registers
    // ----------------------------------------------------------------
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            shift_reg <= 24'h000000;
            count_reg <= 5'h00;
            out_reg <= 8'h00;
            sdo_reg <= 1'b0;
            read_byte_reg <= 8'h00;
            inbound_fail_reg <= 1'b0;
            supply_drop_reg <= 1'b1;
            powerup_fail_reg <= 1'b0;
            gc_reg <= `R_ZERO;
            soft_rst_reg <= 1'b0;
        end else begin
            shift_reg <= shift_next;
            count_reg <= count_next;
            out_reg <= out_next;
            sdo_reg <= sdo_next;
            read_byte_reg <= read_byte_next;
            inbound_fail_reg <= inbound_fail_next;
            supply_drop_reg <= supply_drop_next;
            powerup_fail_reg <= powerup_fail_next;
            gc_reg <= gc_next;
            soft_rst_reg <= soft_rst_next;
        end
    end

    adc_reg_store #(
        .DEPTH(16)
    ) u_store (
        .i_clk(i_clk),
        .i_reset_n(i_reset_n),
        .i_clear(soft_rst_reg),
        .i_we(store_we),
        .i_waddr(f_slot[3:0]),
        .i_wdata(store_wdata),
        .i_raddr(f_slot[3:0]),
        .o_rdata(store_rdata)
    );

    assign o_sdo = sdo_reg;
    assign o_soft_reset_pulse = soft_rst_reg;
endmodule // adc_config_status_regs
`default_nettype wire

// ---- tb/adc_regs_properties.sv ----
// Concurrent checks on the serial port of the register bank
`timescale 1ns/1ps
`default_nettype none
module adc_regs_properties (
    input wire logic i_clk,
    input wire logic i_reset_n,
    input wire logic i_cs_n,
    input wire logic i_sclk,
    input wire logic i_sdi,
    input wire logic i_scan_running,
    input wire logic i_powerup_check_fail,
    input wire logic i_inbound_check_fail,
    input wire logic i_supply_drop,
    input wire logic [7:0] i_digital_in_levels,
    input wire logic o_sdo,
    input wire logic o_soft_reset_pulse
);
    // ------------------------------------------------------------
    // Frame timing checks
    // ------------------------------------------------------------
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_reset_n);

    // Output parked low once the select has settled high
    sdo_idle_a: assert property (i_cs_n [*5] |-> !o_sdo)
        else $error("sdo not low between frames");
    sdo_release_a: assert property ($rose(i_cs_n) |-> ##[1:5] !o_sdo)
        else $error("sdo not released after frame");
    // Reply bits move only while the serial clock is low
    sdo_edge_a: assert property ($changed(o_sdo) |-> !i_sclk)
        else $error("sdo changed with serial clock high");
    sdo_hold_a: assert property (i_sclk && $past(i_sclk) |-> $stable(o_sdo))
        else $error("sdo moved during high phase");
    // Soft reset is one clean pulse, applied only after a frame closes
    rst_pulse_one_a: assert property (o_soft_reset_pulse |=> !o_soft_reset_pulse [*8])
        else $error("soft reset pulse too long");
    rst_after_frame_a: assert property (o_soft_reset_pulse |-> i_cs_n && !i_sclk)
        else $error("soft reset inside a frame");
    no_apply_mid_a: assert property (!i_cs_n [*8] |-> !o_soft_reset_pulse)
        else $error("command applied before select rise");
    apply_late_a: assert property ($rose(i_cs_n) |-> !o_soft_reset_pulse)
        else $error("command applied at select rise");

    cover property (o_soft_reset_pulse);
    cover property (!i_cs_n && o_sdo);
    cover property ($rose(i_cs_n));
endmodule // adc_regs_properties

bind adc_config_status_regs adc_regs_properties u_props (
    .i_clk(i_clk), .i_reset_n(i_reset_n), .i_cs_n(i_cs_n),
    .i_sclk(i_sclk), .i_sdi(i_sdi), .i_scan_running(i_scan_running),
    .i_powerup_check_fail(i_powerup_check_fail),
    .i_inbound_check_fail(i_inbound_check_fail),
    .i_supply_drop(i_supply_drop),
    .i_digital_in_levels(i_digital_in_levels),
    .o_sdo(o_sdo), .o_soft_reset_pulse(o_soft_reset_pulse)
);
`default_nettype wire

// ---- tb/spi_host_model.sv ----
// Behavioural serial host that frames register commands
`timescale 1ns/1ps
`default_nettype none
module spi_host_model #(
    parameter int HALF = 6
) (
    input wire logic i_clk,
    input wire logic i_sdo,
    output logic o_cs_n,
    output logic o_sclk,
    output logic o_sdi
);
    // ------------------------------------------------------------
    // Frame engine
    // ------------------------------------------------------------
    // Idle: deselected, clock parked low
    initial begin
        o_cs_n = 1'b1;
        o_sclk = 1'b0;
        o_sdi = 1'b0;
    end

    // Long phases keep the oversampled serial clock legal
    task automatic frame(input logic [23:0] tx, output logic [23:0] rx);
        rx = 24'h000000;
        @(negedge i_clk);
        o_cs_n = 1'b0;
        for (int i = 23; i >= 0; i--) begin
            o_sdi = tx[i];
            repeat (HALF) @(negedge i_clk);
            rx[i] = i_sdo;
            o_sclk = 1'b1;
            repeat (HALF) @(negedge i_clk);
            o_sclk = 1'b0;
        end
        repeat (HALF) @(negedge i_clk);
        o_cs_n = 1'b1;
        // Released line shows the inverse so a stale bit cannot pass
        o_sdi = ~o_sdi;
        repeat (12) @(negedge i_clk);
    endtask
endmodule // spi_host_model
`default_nettype wire

// ---- tb/tb_top.sv ----
// Self-checking bench for the register bank
`timescale 1ns/1ps
`default_nettype none
`include "adc_regs_map.svh"
`define CHK(nm, e, g) \
    begin \
        n_checks++; \
        if ((g) !== (e)) begin \
            bad_count++; \
            $display("mismatch %s exp %h got %h", nm, e, g); \
        end \
    end
module tb_top;
    logic clk, reset_n, cs_n, sclk, sdi, sdo, rst_pulse;
    logic scan, pfail, ifail, sdrop;
    logic [7:0] din;
    logic [23:0] rx;
    int bad_count = 0;
    int n_checks = 0;
    int cycles = 0;
    int pulses = 0;
    // Defined locations; the host never writes any other address
    localparam logic [7:0] addr_list [17] = '{8'h00, 8'h01, 8'h02,
        8'h03, 8'h04, 8'h05, 8'h07, 8'h09, 8'h0B, 8'h0D, 8'h10, 8'h11,
        8'h12, 8'hBF, 8'hC0, 8'hC1, 8'hC2};

    adc_config_status_regs dut (
        .i_clk(clk), .i_reset_n(reset_n), .i_cs_n(cs_n), .i_sclk(sclk),
        .i_sdi(sdi), .i_scan_running(scan), .i_powerup_check_fail(pfail),
        .i_inbound_check_fail(ifail), .i_supply_drop(sdrop),
        .i_digital_in_levels(din), .o_sdo(sdo),
        .o_soft_reset_pulse(rst_pulse)
    );
    spi_host_model host (
        .i_clk(clk), .i_sdo(sdo), .o_cs_n(cs_n), .o_sclk(sclk), .o_sdi(sdi)
    );

    // ------------------------------------------------------------
    // Clock, watchdog and pulse counter
    // ------------------------------------------------------------
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    // Ceiling sits well above the roughly 46k cycles the tests need
    always @(posedge clk) begin
        cycles++;
        if (rst_pulse === 1'b1) pulses++;
        if (cycles == 80000) begin
            bad_count++;
            $display("timeout");
            end_sim();
        end
    end

    // ------------------------------------------------------------
    // Access tasks
    // ------------------------------------------------------------
    task automatic end_sim();
        $display("checks %0d mismatches %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    task automatic cmd(input logic [7:0] op, a, d);
        host.frame({op, a, d}, rx);
    endtask
    // Read costs two frames: request, then the byte leads the next one
    task automatic rd(input logic [7:0] a, e);
        cmd(`OP_READ, a, 8'h00);
        host.frame(24'h000000, rx);
        `CHK($sformatf("reg %h", a), e, rx[23:16])
    endtask

    // ------------------------------------------------------------
    // Test sequence
    // ------------------------------------------------------------
    initial begin
        {reset_n, scan, pfail, ifail, sdrop} = 5'h00;
        din = 8'h00;
        repeat (4) @(negedge clk);
        reset_n = 1'b1;
        repeat (4) @(negedge clk);
        foreach (addr_list[i]) rd(addr_list[i], addr_list[i] == 8'h00 ?
            8'h81 : (addr_list[i] == 8'h04 ? 8'h01 : 8'h00));
        $display("test reset values done");
        // Plain registers take a distinct byte each; pin-fed one does not
        for (int i = 2; i < 17; i++)
            cmd(`OP_WRITE, addr_list[i], 8'(8'hA5 ^ i));
        din = 8'h5A;
        for (int i = 2; i < 17; i++) rd(addr_list[i],
            i == 9 ? 8'h5A : 8'(8'hA5 ^ i));
        // Pin-fed register ignores a set; undefined address reads zero
        cmd(`OP_SET_BITS, 8'h0D, 8'hFF);
        rd(8'h0D, 8'h5A);
        rd(8'h06, 8'h00);
        cmd(`OP_WRITE, 8'h01, 8'h3C);
        rd(8'h01, 8'h0C);
        cmd(`OP_SET_BITS, 8'h01, 8'h80);
        rd(8'h01, 8'h8C);
        cmd(`OP_SET_BITS, 8'h02, 8'h0F);
        rd(8'h02, 8'hAF);
        cmd(`OP_CLEAR_BITS, 8'h02, 8'h05);
        cmd(`OP_NOP, 8'h02, 8'hFF);
        cmd(8'h28, 8'h02, 8'hFF);
        rd(8'h02, 8'hAA);
        $display("test write paths done");
        scan = 1'b1;
        rd(8'h00, 8'hC1);
        cmd(`OP_WRITE, 8'h00, 8'h00);
        rd(8'h00, 8'hC1);
        cmd(`OP_WRITE, 8'h00, 8'h01);
        rd(8'h00, 8'hC0);
        sdrop = 1'b1;
        repeat (8) @(negedge clk);
        sdrop = 1'b0;
        rd(8'h00, 8'hC1);
        rd(8'h00, 8'hC1);
        cmd(`OP_WRITE, 8'h00, 8'h01);
        scan = 1'b0;
        rd(8'h00, 8'h80);
        $display("test status flags done");
        ifail = 1'b1;
        repeat (8) @(negedge clk);
        ifail = 1'b0;
        rd(8'h00, 8'h82);
        cmd(`OP_WRITE, 8'h02, 8'h11);
        rd(8'h02, 8'hAA);
        cmd(`OP_WRITE, 8'h01, 8'h08);
        rd(8'h01, 8'h08);
        cmd(`OP_WRITE, 8'h00, 8'h02);
        rd(8'h00, 8'h80);
        cmd(`OP_WRITE, 8'h02, 8'h11);
        rd(8'h02, 8'h11);
        $display("test inbound error done");
        pfail = 1'b1;
        cmd(`OP_WRITE, 8'h00, 8'h04);
        rd(8'h00, 8'h80);
        cmd(`OP_WRITE, 8'h01, 8'h01);
        `CHK("soft reset pulses", 1, pulses)
        rd(8'h00, 8'h85);
        rd(8'h01, 8'h00);
        rd(8'h02, 8'h00);
        rd(8'h04, 8'h01);
        pfail = 1'b0;
        cmd(`OP_WRITE, 8'h00, 8'h01);
        rd(8'h00, 8'h84);
        cmd(`OP_WRITE, 8'h01, 8'h01);
        `CHK("soft reset pulses", 2, pulses)
        rd(8'h00, 8'h81);
        $display("test soft reset done");
        // A power cycle in mid-run must read the check pin again
        pfail = 1'b1;
        cmd(`OP_WRITE, 8'h02, 8'h33);
        reset_n = 1'b0;
        repeat (4) @(negedge clk);
        reset_n = 1'b1;
        repeat (4) @(negedge clk);
        rd(8'h00, 8'h85);
        rd(8'h02, 8'h00);
        pfail = 1'b0;
        $display("test power cycle done");
        end_sim();
    end
endmodule // tb_top
`default_nettype wire
